/* hw/hpm_pkg.sv */
// Constants, register map and types of the haptic playback mode controller
package hpm_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_ACT_CFG = 8'h00;
  localparam logic [7:0] ADDR_NOM_MAX = 8'h01;
  localparam logic [7:0] ADDR_ABS_MAX = 8'h02;
  localparam logic [7:0] ADDR_CURRENT_LIMIT = 8'h03;
  localparam logic [7:0] ADDR_IMPEDANCE_HIGH = 8'h04;
  localparam logic [7:0] ADDR_IMPEDANCE_LOW = 8'h05;
  localparam logic [7:0] ADDR_PERIOD_HIGH = 8'h06;
  localparam logic [7:0] ADDR_PERIOD_LOW = 8'h07;
  localparam logic [7:0] ADDR_STORE_LOCK = 8'h08;
  localparam logic [7:0] ADDR_STORE_BASE = 8'h09;
  localparam logic [7:0] ADDR_OP_MODE = 8'h0a;
  localparam logic [7:0] ADDR_DIRECT_AMP = 8'h0b;
  localparam logic [7:0] ADDR_ZERO_THR = 8'h0c;
  localparam logic [7:0] ADDR_SEQ_SEL = 8'h0d;
  localparam logic [7:0] ADDR_SEQ_CTRL = 8'h0e;
  localparam logic [7:0] ADDR_STATUS = 8'h0f;
  localparam logic [7:0] ADDR_PIN_CFG0 = 8'h10;
  localparam logic [7:0] ADDR_DUTY = 8'h13;

  // Field positions
  localparam int ACT_TYPE_BIT = 0;
  localparam int TRACK_EN_BIT = 1;
  localparam int ACCEL_EN_BIT = 2;
  localparam int BRAKE_EN_BIT = 3;
  localparam int STANDBY_EN_BIT = 4;
  localparam int START_BIT = 0;
  localparam int CONTINUE_BIT = 1;
  localparam int FINISHED_BIT = 0;
  localparam int PERIOD_SPLIT = 7;
  localparam int SEQ_LOOP_POS = 4;
  localparam int PIN_STYLE_BIT = 2;
  localparam int PIN_SEQ_POS = 3;

  // Reset values
  localparam logic [7:0] ACT_CFG_RST = 8'h00;
  localparam logic [7:0] PIN_CFG_RST = 8'h00;
  localparam logic [7:0] PATTERN_STORE_BASE_VAL = 8'h20;

  // Drive levels
  localparam logic [7:0] FULL_REVERSE_AMP = 8'hff;
  localparam logic [7:0] SIGN_FLIP = 8'h80;
  localparam logic [8:0] DUTY_MID = 9'h080;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned WAKE_TIME_NS = 750_000;
  localparam int unsigned WAKE_CYCLES = WAKE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned BRAKE_TIME_NS = 200_000;
  localparam int unsigned BRAKE_CYCLES = BRAKE_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0] PWM_WINDOW_LAST = 8'hff;

  // Trigger edge selection
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  typedef enum logic [2:0] {
    mode_inactive = 3'h0,
    direct_override_mode = 3'h1,
    pwm_mode = 3'h2,
    register_started_playback = 3'h3,
    edge_started_playback = 3'h4
  } hpm_mode_e;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_wake = 2'b01,
    st_drive = 2'b11,
    st_standby = 2'b10
  } hpm_state_e;

  typedef struct packed {
    logic erm_type;
    logic [7:0] nom_max;
    logic [7:0] abs_max;
    logic [4:0] current_limit_code;
    logic [15:0] impedance_factor;
    logic [14:0] resonant_period;
  } hpm_act_s;

  typedef struct packed {
    logic enable;
    logic [7:0] amplitude;
    logic signed_data;
    logic overdrive_ok;
    logic reverse;
    logic phase_flip;
    logic invert;
  } hpm_drive_s;

endpackage

/* hw/hpm_ctrl.sv */
// Haptic playback mode controller: settings, mode sequencing, triggers and drive control
//
// The placing of the registers and strobed register access are this design's own decisions.
module hpm_ctrl #(
  parameter int unsigned WAKE_CYCLES = hpm_pkg::WAKE_CYCLES,
  parameter int unsigned BRAKE_CYCLES = hpm_pkg::BRAKE_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  // Trigger and duty pins
  input wire logic shared_trigger_duty_pin,
  input wire logic [1:0] trigger_pins,
  // Waveform player
  input wire logic seq_end,
  input wire logic [7:0] player_amp,
  output logic seq_go_q,
  output logic [3:0] seq_sel_q,
  output logic pattern_store_unlocked_q,
  // Actuator settings and drive
  output hpm_pkg::hpm_act_s act_cfg_q,
  output hpm_pkg::hpm_drive_s drive_q,
  // Open-drain interrupt pin
  output logic interrupt_line_n_out_q,
  output logic interrupt_line_n_oe_q
);

  // Settings registers
  hpm_pkg::hpm_act_s act_cfg_d;
  logic [7:0] ctl_cfg_q, ctl_cfg_d;
  logic lock_d;
  logic [2:0] op_mode_q, op_mode_d;
  logic [7:0] direct_amplitude_q, direct_amplitude_d;
  logic [7:0] zero_drive_threshold_q, zero_drive_threshold_d;
  logic [7:0] seq_cfg_q, seq_cfg_d;
  logic [7:0] pin_cfg_q [3];
  logic [7:0] pin_cfg_d [3];
  logic [7:0] rdata_d;

  // Pin sampling and duty measurement
  logic [2:0] pin_raw;
  logic [2:0] sync1_q, sync2_q, sync3_q;
  logic [2:0] lvl_q, lvl_d;
  logic [2:0] rise, fall;
  logic [7:0] win_q, win_d;
  logic [8:0] high_q, high_d;
  logic [7:0] duty_q, duty_d;

  // Sequencing
  hpm_pkg::hpm_state_e state_q, state_d, rest_state;
  logic [2:0] run_mode_q, run_mode_d;
  logic [19:0] wake_cnt_q, wake_cnt_d;
  logic [19:0] brake_cnt_q, brake_cnt_d;
  logic [3:0] loops_q, loops_d;
  logic [3:0] seq_sel_d;
  logic [2:0] alt_q, alt_d;
  logic start_q, start_d;
  logic finished_q, finished_d;
  logic prev_nz_q, prev_nz_d;
  logic seq_go_d;
  hpm_pkg::hpm_drive_s drive_d;

  logic standby_en, accel_en, track_en, brake_en;
  logic ctrl_wr, start_wr1, start_wr0, cont_wr, mem_mode, abort;
  logic edge_ev;
  logic [3:0] edge_seq;
  logic [7:0] target;
  logic [8:0] duty_off;
  logic [7:0] pwm_mag;
  logic pwm_zero;

  assign standby_en = ctl_cfg_q[hpm_pkg::STANDBY_EN_BIT];
  assign accel_en = ctl_cfg_q[hpm_pkg::ACCEL_EN_BIT];
  assign track_en = ctl_cfg_q[hpm_pkg::TRACK_EN_BIT];
  assign brake_en = ctl_cfg_q[hpm_pkg::BRAKE_EN_BIT];
  assign pin_raw = {trigger_pins, shared_trigger_duty_pin};

  // Register writes and read-back
  always_comb begin
    act_cfg_d = act_cfg_q;
    ctl_cfg_d = ctl_cfg_q;
    lock_d = pattern_store_unlocked_q;
    op_mode_d = op_mode_q;
    direct_amplitude_d = direct_amplitude_q;
    zero_drive_threshold_d = zero_drive_threshold_q;
    seq_cfg_d = seq_cfg_q;
    for (int i = 0; i < 3; i++) begin
      pin_cfg_d[i] = pin_cfg_q[i];
    end
    rdata_d = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        hpm_pkg::ADDR_ACT_CFG: begin
          ctl_cfg_d = reg_wdata;
          act_cfg_d.erm_type = reg_wdata[hpm_pkg::ACT_TYPE_BIT];
        end
        hpm_pkg::ADDR_NOM_MAX: act_cfg_d.nom_max = reg_wdata;
        hpm_pkg::ADDR_ABS_MAX: act_cfg_d.abs_max = reg_wdata;
        hpm_pkg::ADDR_CURRENT_LIMIT: act_cfg_d.current_limit_code = reg_wdata[4:0];
        hpm_pkg::ADDR_IMPEDANCE_HIGH: act_cfg_d.impedance_factor[15:8] = reg_wdata;
        hpm_pkg::ADDR_IMPEDANCE_LOW: act_cfg_d.impedance_factor[7:0] = reg_wdata;
        hpm_pkg::ADDR_PERIOD_HIGH: begin
          act_cfg_d.resonant_period[14:hpm_pkg::PERIOD_SPLIT] = reg_wdata;
        end
        hpm_pkg::ADDR_PERIOD_LOW: begin
          act_cfg_d.resonant_period[hpm_pkg::PERIOD_SPLIT-1:0] = reg_wdata[6:0];
        end
        hpm_pkg::ADDR_STORE_LOCK: lock_d = reg_wdata[0];
        hpm_pkg::ADDR_OP_MODE: op_mode_d = reg_wdata[2:0];
        hpm_pkg::ADDR_DIRECT_AMP: direct_amplitude_d = reg_wdata;
        hpm_pkg::ADDR_ZERO_THR: zero_drive_threshold_d = reg_wdata;
        hpm_pkg::ADDR_SEQ_SEL: seq_cfg_d = reg_wdata;
        hpm_pkg::ADDR_PIN_CFG0: pin_cfg_d[0] = reg_wdata;
        hpm_pkg::ADDR_PIN_CFG0 + 8'h01: pin_cfg_d[1] = reg_wdata;
        hpm_pkg::ADDR_PIN_CFG0 + 8'h02: pin_cfg_d[2] = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        hpm_pkg::ADDR_ACT_CFG: rdata_d = ctl_cfg_q;
        hpm_pkg::ADDR_NOM_MAX: rdata_d = act_cfg_q.nom_max;
        hpm_pkg::ADDR_ABS_MAX: rdata_d = act_cfg_q.abs_max;
        hpm_pkg::ADDR_CURRENT_LIMIT: rdata_d = {3'h0, act_cfg_q.current_limit_code};
        hpm_pkg::ADDR_IMPEDANCE_HIGH: rdata_d = act_cfg_q.impedance_factor[15:8];
        hpm_pkg::ADDR_IMPEDANCE_LOW: rdata_d = act_cfg_q.impedance_factor[7:0];
        hpm_pkg::ADDR_PERIOD_HIGH: rdata_d = act_cfg_q.resonant_period[14:7];
        hpm_pkg::ADDR_PERIOD_LOW: rdata_d = {1'b0, act_cfg_q.resonant_period[6:0]};
        hpm_pkg::ADDR_STORE_LOCK: rdata_d = {7'h00, pattern_store_unlocked_q};
        hpm_pkg::ADDR_STORE_BASE: rdata_d = hpm_pkg::PATTERN_STORE_BASE_VAL;
        hpm_pkg::ADDR_OP_MODE: rdata_d = {5'h00, op_mode_q};
        hpm_pkg::ADDR_DIRECT_AMP: rdata_d = direct_amplitude_q;
        hpm_pkg::ADDR_ZERO_THR: rdata_d = zero_drive_threshold_q;
        hpm_pkg::ADDR_SEQ_SEL: rdata_d = seq_cfg_q;
        hpm_pkg::ADDR_SEQ_CTRL: rdata_d = {7'h00, start_q};
        hpm_pkg::ADDR_STATUS: rdata_d = {5'h00, state_q, finished_q};
        hpm_pkg::ADDR_PIN_CFG0: rdata_d = pin_cfg_q[0];
        hpm_pkg::ADDR_PIN_CFG0 + 8'h01: rdata_d = pin_cfg_q[1];
        hpm_pkg::ADDR_PIN_CFG0 + 8'h02: rdata_d = pin_cfg_q[2];
        hpm_pkg::ADDR_DUTY: rdata_d = duty_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      act_cfg_q <= '0;
      ctl_cfg_q <= hpm_pkg::ACT_CFG_RST;
      pattern_store_unlocked_q <= 1'b0;
      op_mode_q <= hpm_pkg::mode_inactive;
      direct_amplitude_q <= 8'h00;
      zero_drive_threshold_q <= 8'h00;
      seq_cfg_q <= 8'h00;
      for (int i = 0; i < 3; i++) begin
        pin_cfg_q[i] <= hpm_pkg::PIN_CFG_RST;
      end
      reg_rdata_q <= 8'h00;
    end else begin
      act_cfg_q <= act_cfg_d;
      ctl_cfg_q <= ctl_cfg_d;
      pattern_store_unlocked_q <= lock_d;
      op_mode_q <= op_mode_d;
      direct_amplitude_q <= direct_amplitude_d;
      zero_drive_threshold_q <= zero_drive_threshold_d;
      seq_cfg_q <= seq_cfg_d;
      for (int i = 0; i < 3; i++) begin
        pin_cfg_q[i] <= pin_cfg_d[i];
      end
      reg_rdata_q <= rdata_d;
    end
  end

  // Pin filtering, edge events and duty measurement
  always_comb begin
    lvl_d = lvl_q;
    rise = 3'h0;
    fall = 3'h0;
    for (int i = 0; i < 3; i++) begin
      if (sync2_q[i] == sync3_q[i] && sync3_q[i] != lvl_q[i]) begin
        lvl_d[i] = sync3_q[i];
        rise[i] = sync3_q[i];
        fall[i] = ~sync3_q[i];
      end
    end
    win_d = win_q + 8'h01;
    high_d = high_q + {8'h00, lvl_q[0]};
    duty_d = duty_q;
    if (win_q == hpm_pkg::PWM_WINDOW_LAST) begin
      duty_d = high_d[8] ? 8'hff : high_d[7:0];
      high_d = 9'h000;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
      lvl_q <= 3'h0;
      win_q <= 8'h00;
      high_q <= 9'h000;
      duty_q <= 8'h00;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      lvl_q <= lvl_d;
      win_q <= win_d;
      high_q <= high_d;
      duty_q <= duty_d;
    end
  end

  // Qualified trigger events and the sequence each one selects
  always_comb begin
    edge_ev = 1'b0;
    edge_seq = 4'h0;
    alt_d = alt_q;
    for (int i = 2; i >= 0; i--) begin
      if ((rise[i] && (pin_cfg_q[i][1:0] == hpm_pkg::EDGE_RISE ||
                       pin_cfg_q[i][1:0] == hpm_pkg::EDGE_BOTH)) ||
          (fall[i] && (pin_cfg_q[i][1:0] == hpm_pkg::EDGE_FALL ||
                       pin_cfg_q[i][1:0] == hpm_pkg::EDGE_BOTH))) begin
        edge_ev = 1'b1;
        edge_seq = pin_cfg_q[i][hpm_pkg::PIN_SEQ_POS +: 4] +
                   {3'h0, alt_q[i] & pin_cfg_q[i][hpm_pkg::PIN_STYLE_BIT]};
        if (op_mode_q == hpm_pkg::edge_started_playback &&
            pin_cfg_q[i][hpm_pkg::PIN_STYLE_BIT]) begin
          alt_d[i] = ~alt_q[i];
        end
      end
    end
  end

  // PWM duty to signed or unsigned amplitude
  always_comb begin
    duty_off = {1'b0, duty_q} - hpm_pkg::DUTY_MID;
    pwm_mag = duty_off[8] ? 8'(~duty_off + 9'h001) : duty_off[7:0];
    if (accel_en) begin
      pwm_zero = pwm_mag <= zero_drive_threshold_q;
    end else begin
      pwm_zero = duty_q <= zero_drive_threshold_q;
    end
  end

  // Mode sequencing, completion and drive control
  always_comb begin
    state_d = state_q;
    run_mode_d = run_mode_q;
    wake_cnt_d = wake_cnt_q;
    brake_cnt_d = brake_cnt_q;
    loops_d = loops_q;
    seq_sel_d = seq_sel_q;
    start_d = start_q;
    finished_d = finished_q;
    seq_go_d = 1'b0;
    ctrl_wr = reg_wr && reg_addr == hpm_pkg::ADDR_SEQ_CTRL;
    start_wr1 = ctrl_wr && reg_wdata[hpm_pkg::START_BIT];
    start_wr0 = ctrl_wr && !reg_wdata[hpm_pkg::START_BIT];
    cont_wr = ctrl_wr && reg_wdata[hpm_pkg::CONTINUE_BIT];
    mem_mode = run_mode_q == hpm_pkg::register_started_playback ||
               run_mode_q == hpm_pkg::edge_started_playback;
    abort = op_mode_q != run_mode_q || (mem_mode && start_wr0);
    rest_state = standby_en ? hpm_pkg::st_standby : hpm_pkg::st_idle;
    if (start_wr1) begin
      start_d = 1'b1;
    end else if (start_wr0) begin
      start_d = 1'b0;
    end
    if (reg_wr && reg_addr == hpm_pkg::ADDR_STATUS && reg_wdata[hpm_pkg::FINISHED_BIT]) begin
      finished_d = 1'b0;
    end
    case (state_q)
      hpm_pkg::st_idle, hpm_pkg::st_standby: begin
        wake_cnt_d = 20'h00000;
        run_mode_d = op_mode_q;
        loops_d = seq_cfg_q[hpm_pkg::SEQ_LOOP_POS +: 4];
        case (op_mode_q)
          hpm_pkg::direct_override_mode, hpm_pkg::pwm_mode: state_d = hpm_pkg::st_wake;
          hpm_pkg::register_started_playback: begin
            if (start_wr1) begin
              state_d = hpm_pkg::st_wake;
              seq_sel_d = seq_cfg_q[3:0];
            end
          end
          hpm_pkg::edge_started_playback: begin
            if (start_wr1) begin
              state_d = hpm_pkg::st_wake;
              seq_sel_d = seq_cfg_q[3:0];
            end else if (edge_ev) begin
              state_d = hpm_pkg::st_wake;
              seq_sel_d = edge_seq;
            end
          end
          default: ;
        endcase
      end
      hpm_pkg::st_wake: begin
        if (abort) begin
          state_d = rest_state;
        end else if (wake_cnt_q == 20'(WAKE_CYCLES - 1)) begin
          state_d = hpm_pkg::st_drive;
          seq_go_d = mem_mode;
        end else begin
          wake_cnt_d = wake_cnt_q + 20'h00001;
        end
      end
      hpm_pkg::st_drive: begin
        if (abort) begin
          state_d = rest_state;
        end else if (mem_mode) begin
          if (edge_ev && run_mode_q == hpm_pkg::edge_started_playback) begin
            state_d = rest_state;
          end else if (cont_wr) begin
            seq_go_d = 1'b1;
            loops_d = seq_cfg_q[hpm_pkg::SEQ_LOOP_POS +: 4];
          end else if (seq_end) begin
            if (loops_q != 4'h0) begin
              loops_d = loops_q - 4'h1;
              seq_go_d = 1'b1;
            end else begin
              finished_d = 1'b1;
              start_d = 1'b0;
              state_d = rest_state;
            end
          end
        end
      end
      default: state_d = hpm_pkg::st_idle;
    endcase

    case (run_mode_q)
      hpm_pkg::direct_override_mode: target = direct_amplitude_q;
      hpm_pkg::pwm_mode: begin
        if (pwm_zero) begin
          target = 8'h00;
        end else begin
          target = accel_en ? (duty_q ^ hpm_pkg::SIGN_FLIP) : duty_q;
        end
      end
      default: target = player_amp;
    endcase
    if (state_q != hpm_pkg::st_drive) begin
      target = 8'h00;
    end
    prev_nz_d = target != 8'h00;
    if (target != 8'h00) begin
      brake_cnt_d = 20'h00000;
    end else if (prev_nz_q && brake_en && track_en) begin
      brake_cnt_d = 20'(BRAKE_CYCLES);
    end else if (brake_cnt_q != 20'h00000) begin
      brake_cnt_d = brake_cnt_q - 20'h00001;
    end
    drive_d.reverse = brake_cnt_d != 20'h00000;
    drive_d.phase_flip = drive_d.reverse && !act_cfg_q.erm_type;
    drive_d.invert = drive_d.reverse && act_cfg_q.erm_type;
    drive_d.enable = target != 8'h00 || drive_d.reverse;
    drive_d.amplitude = drive_d.reverse ? hpm_pkg::FULL_REVERSE_AMP : target;
    drive_d.signed_data = accel_en;
    drive_d.overdrive_ok = accel_en && track_en;
    if (state_d != hpm_pkg::st_drive && state_d != hpm_pkg::st_wake) begin
      seq_go_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= hpm_pkg::st_idle;
      run_mode_q <= hpm_pkg::mode_inactive;
      wake_cnt_q <= 20'h00000;
      brake_cnt_q <= 20'h00000;
      loops_q <= 4'h0;
      seq_sel_q <= 4'h0;
      alt_q <= 3'h0;
      start_q <= 1'b0;
      finished_q <= 1'b0;
      prev_nz_q <= 1'b0;
      seq_go_q <= 1'b0;
      drive_q <= '0;
      interrupt_line_n_out_q <= 1'b0;
      interrupt_line_n_oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      run_mode_q <= run_mode_d;
      wake_cnt_q <= wake_cnt_d;
      brake_cnt_q <= brake_cnt_d;
      loops_q <= loops_d;
      seq_sel_q <= seq_sel_d;
      alt_q <= alt_d;
      start_q <= start_d;
      finished_q <= finished_d;
      prev_nz_q <= prev_nz_d;
      seq_go_q <= seq_go_d;
      drive_q <= drive_d;
      interrupt_line_n_out_q <= 1'b0;
      interrupt_line_n_oe_q <= finished_d;
    end
  end

endmodule

/* testbench/hpm_ctrl_assertions.sv */
// Port assertions for the playback mode controller
module hpm_ctrl_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  // Player and outputs
  input wire logic seq_end,
  input wire logic seq_go_q,
  input wire logic pattern_store_unlocked_q,
  input wire hpm_pkg::hpm_act_s act_cfg_q,
  input wire hpm_pkg::hpm_drive_s drive_q,
  input wire logic interrupt_line_n_oe_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  base_read_a: assert property (
    reg_rd && reg_addr == hpm_pkg::ADDR_STORE_BASE
    |=> reg_rdata_q == hpm_pkg::PATTERN_STORE_BASE_VAL) else $error("store base wrong");
  lock_follow_a: assert property (
    reg_wr && reg_addr == hpm_pkg::ADDR_STORE_LOCK
    |=> pattern_store_unlocked_q == $past(reg_wdata[0])) else $error("lock bit wrong");
  act_type_a: assert property (
    reg_wr && reg_addr == hpm_pkg::ADDR_ACT_CFG
    |=> act_cfg_q.erm_type == $past(reg_wdata[0])) else $error("type bit wrong");
  imp_high_a: assert property (
    reg_wr && reg_addr == hpm_pkg::ADDR_IMPEDANCE_HIGH
    |=> act_cfg_q.impedance_factor[15:8] == $past(reg_wdata)) else $error("impedance wrong");
  period_low_a: assert property (
    reg_wr && reg_addr == hpm_pkg::ADDR_PERIOD_LOW
    |=> act_cfg_q.resonant_period[6:0] == $past(reg_wdata[6:0])) else $error("period wrong");
  done_cause_a: assert property (
    $rose(interrupt_line_n_oe_q) |-> $past(seq_end)) else $error("done without end");
  go_single_a: assert property (
    seq_go_q |=> !seq_go_q) else $error("start pulse too long");
  reverse_full_a: assert property (
    drive_q.reverse |-> drive_q.amplitude == hpm_pkg::FULL_REVERSE_AMP
    && drive_q.invert == act_cfg_q.erm_type) else $error("reverse drive wrong");
endmodule

bind hpm_ctrl hpm_ctrl_checker u_hpm_ctrl_checker (.sys_clk(sys_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .seq_end(seq_end), .seq_go_q(seq_go_q),
  .pattern_store_unlocked_q(pattern_store_unlocked_q), .act_cfg_q(act_cfg_q),
  .drive_q(drive_q), .interrupt_line_n_oe_q(interrupt_line_n_oe_q));

/* testbench/hpm_player_model.sv */
// Behavioural waveform player facing the controller
module hpm_player_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Controller side
  input wire logic seq_go_q,
  input wire logic [3:0] seq_sel_q,
  input wire logic slow,
  output logic seq_end,
  output logic [7:0] player_amp
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      left <= 8'h00;
      seq_end <= 1'b0;
    end else begin
      seq_end <= left == 8'h01;
      if (seq_go_q) left <= slow ? 8'h40 : 8'h14;
      else if (left != 8'h00) left <= left - 8'h01;
    end
  end
  assign player_amp = (left != 8'h00) ? {4'h4, seq_sel_q} : ~{4'h4, seq_sel_q};
endmodule

/* testbench/tb.sv */
// Self-checking bench for the playback mode controller
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst, reg_wr, reg_rd, pin0, seq_end, seq_go_q, unl, oe, oe_out, slow;
  logic [7:0] reg_addr, reg_wdata, rdata, amp;
  logic [1:0] pins;
  logic [3:0] sel;
  logic [7:0] cfg [8] = '{8'h0b, 8'h80, 8'hc0, 8'h11, 8'h12, 8'h34, 8'h2a, 8'hd5};
  hpm_pkg::hpm_act_s act;
  hpm_pkg::hpm_drive_s drv;
  int errors = 0, tests_run = 0, gos = 0, cycles = 0;
  wire irq_n = oe ? oe_out : 1'b1;
  logic pwm_on = 1'b0;
  logic [2:0] pwm_ph = 3'h0;
  logic [2:0] pwm_high = 3'h6;
  wire pin_in = pwm_on ? (pwm_ph < pwm_high) : pin0;
  always @(posedge sys_clk) pwm_ph <= pwm_ph + 3'h1;
  hpm_ctrl #(.WAKE_CYCLES(8), .BRAKE_CYCLES(4)) u_hpm_ctrl (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(rdata), .shared_trigger_duty_pin(pin_in), .trigger_pins(pins),
    .seq_end(seq_end), .player_amp(amp), .seq_go_q(seq_go_q), .seq_sel_q(sel),
    .pattern_store_unlocked_q(unl), .act_cfg_q(act), .drive_q(drv),
    .interrupt_line_n_out_q(oe_out), .interrupt_line_n_oe_q(oe));
  hpm_player_model u_hpm_player_model (.sys_clk(sys_clk), .rst(rst), .seq_go_q(seq_go_q),
    .seq_sel_q(sel), .slow(slow), .seq_end(seq_end), .player_amp(amp));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (seq_go_q === 1'b1) gos <= gos + 1;
    if (cycles == 42000) begin
      errors = errors + 1;
      print_verdict();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    while (oe !== 1'b1 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    #1 chk(irq_n, 1'b0);
  endtask
  initial begin
    {reg_wr, reg_rd, pin0, pins, slow} = '0;
    {reg_addr, reg_wdata} = '0;
    rst = 1'b1;
    cyc(6);
    rst <= 1'b0;
    rd(hpm_pkg::ADDR_OP_MODE, 8'h00);
    wr(hpm_pkg::ADDR_STORE_BASE, 8'h55);
    rd(8'h3f, 8'h00);
    cyc(37500);
    wr(hpm_pkg::ADDR_STORE_LOCK, 8'h01);
    #1 chk(unl, 1'b1);
    rd(hpm_pkg::ADDR_STORE_BASE, hpm_pkg::PATTERN_STORE_BASE_VAL);
    wr(hpm_pkg::ADDR_STORE_LOCK, 8'h00);
    #1 chk(unl, 1'b0);
    for (int i = 0; i < 8; i++) wr(hpm_pkg::ADDR_ACT_CFG + 8'(i), cfg[i]);
    #1 chk(act, {1'b1, 8'h80, 8'hc0, 5'h11, 16'h1234, 8'h2a, 7'h55});
    wr(hpm_pkg::ADDR_DIRECT_AMP, 8'h60);
    wr(hpm_pkg::ADDR_OP_MODE, 8'h01);
    cyc(12);
    rd(hpm_pkg::ADDR_STATUS, 8'h06);
    chk({drv.enable, drv.amplitude, drv.signed_data}, 10'h2c0);
    wr(hpm_pkg::ADDR_DIRECT_AMP, 8'h7f);
    cyc(2);
    #1 chk(drv.amplitude, 8'h7f);
    wr(hpm_pkg::ADDR_DIRECT_AMP, 8'h00);
    cyc(2);
    #1 chk({drv.reverse, drv.invert, drv.amplitude}, 10'h3ff);
    cyc(8);
    #1 chk(drv.enable, 1'b0);
    rd(hpm_pkg::ADDR_STATUS, 8'h06);
    wr(hpm_pkg::ADDR_OP_MODE, 8'h00);
    cyc(8);
    rd(hpm_pkg::ADDR_STATUS, 8'h00);
    wr(hpm_pkg::ADDR_ACT_CFG, 8'h1b);
    wr(hpm_pkg::ADDR_SEQ_SEL, 8'h15);
    wr(hpm_pkg::ADDR_OP_MODE, 8'h03);
    cyc(12);
    chk(gos, 0);
    wr(hpm_pkg::ADDR_SEQ_CTRL, 8'h01);
    wait_done();
    chk({gos[7:0], sel}, 12'h025);
    rd(hpm_pkg::ADDR_STATUS, 8'h05);
    rd(hpm_pkg::ADDR_SEQ_CTRL, 8'h00);
    wr(hpm_pkg::ADDR_STATUS, 8'h01);
    rd(hpm_pkg::ADDR_STATUS, 8'h04);
    chk(irq_n, 1'b1);
    slow <= 1'b1;
    wr(hpm_pkg::ADDR_SEQ_CTRL, 8'h01);
    cyc(12);
    wr(hpm_pkg::ADDR_SEQ_CTRL, 8'h03);
    cyc(3);
    #1 chk(gos[7:0], 8'h04);
    wr(hpm_pkg::ADDR_SEQ_CTRL, 8'h00);
    cyc(8);
    rd(hpm_pkg::ADDR_STATUS, 8'h04);
    wr(hpm_pkg::ADDR_PIN_CFG0, 8'h3c);
    wr(hpm_pkg::ADDR_OP_MODE, 8'h04);
    slow <= 1'b0;
    pin0 <= 1'b1;
    wait_done();
    chk(sel, 4'h7);
    wr(hpm_pkg::ADDR_STATUS, 8'h01);
    slow <= 1'b1;
    pin0 <= 1'b0;
    cyc(20);
    chk(gos[7:0], 8'h06);
    pin0 <= 1'b1;
    cyc(16);
    chk(sel, 4'h8);
    pins <= 2'b01;
    cyc(16);
    rd(hpm_pkg::ADDR_STATUS, 8'h04);
    wr(hpm_pkg::ADDR_ACT_CFG, 8'h1f);
    wr(hpm_pkg::ADDR_ZERO_THR, 8'h10);
    wr(hpm_pkg::ADDR_OP_MODE, 8'h02);
    pwm_on <= 1'b1;
    cyc(600);
    rd(hpm_pkg::ADDR_DUTY, 8'hc0);
    chk({drv.enable, drv.amplitude, drv.signed_data, drv.overdrive_ok}, 11'h503);
    cyc(1);
    pwm_high <= 3'h4;
    cyc(600);
    #1 chk({drv.enable, drv.reverse}, 2'h0);
    rd(hpm_pkg::ADDR_STATUS, 8'h06);
    print_verdict();
  end
endmodule
